//--- mcrb_cfg_bank.sv
// Configuration register bank reached by I2C packets with optional check byte.
// Assumes a framing layer: one rx strobe per byte, address bytes flagged,
// stop as a pulse, and a tx byte handshake for read data.
`timescale 1ns/1ps
module mcrb_cfg_bank import mcrb_pkg::*; (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        en_i,
  // Received bytes
  input  wire logic        rx_valid_i,
  input  wire logic        rx_addr_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        stop_i,
  // Read data out
  output logic             tx_valid_o,
  output logic      [7:0]  tx_byte_o,
  input  wire logic        tx_ack_i,
  // Events
  output logic             wr_done_o,
  output logic             crc_err_o,
  // Initial speed detect settings
  output logic             parity_o,
  output logic             speed_detect_on_o,
  output logic             braking_on_o,
  output logic             float_outputs_on_o,
  output logic             reverse_spin_on_o,
  output logic             resync_on_o,
  output logic      [3:0]  forward_resync_threshold_o,
  output logic             braking_leg_select_o,
  output logic      [3:0]  braking_duration_o,
  output logic      [13:0] braking_ms_o,
  output logic      [3:0]  float_duration_o,
  output logic      [13:0] float_ms_o,
  output logic      [2:0]  standstill_threshold_o,
  output logic      [3:0]  reverse_handoff_threshold_o,
  output logic      [1:0]  reverse_open_loop_current_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mcrb_state_t       st_r;
  logic [3:0]        cnt_r;
  logic [23:0]       cw_r;
  logic [23:0]       cw_nxt;
  logic [63:0]       wbuf_r;
  logic [63:0]       tbuf_r;
  logic [7:0]        crc_r;
  logic [7:0]        crc_cw_r;
  logic              crc_ok_r;
  logic              rd_armed_r;
  logic [3:0]        ptr_r;
  logic [3:0]        ptr_nxt;
  logic [7:0]        tx_byte_r;
  logic [7:0]        crc_src;
  logic [7:0]        crc_dat;
  logic [7:0]        crc_out;
  logic [3:0]        nbyt;
  logic [3:0]        wr_len;
  logic [3:0]        data_pos;
  logic [4:0]        map0;
  logic [4:0]        map1;
  logic              cw_crc;
  logic              cw_read;
  logic              open_st;
  logic              new_pkt;
  logic              rd_addr;
  logic              rx_data;
  logic              crc_pos;
  logic              stop_ev;
  logic              len_ok;
  logic              commit_go;
  logic              tx_step;
  logic              tx_last;
  logic              mem_we;
  logic [3:0]        mem_widx;
  logic [1:0]        mem_wmask;
  logic [WORD_W-1:0] mem_wdata;
  logic [3:0]        mem_ridx;
  logic [WORD_W-1:0] mem_rdata;
  logic [WORD_W-1:0] isd_w;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] dlen_bytes(input logic [1:0] d);
    logic [3:0] n;
    n = 4'h0;
    unique case (d)
      DLEN_16: n = NB_16;
      DLEN_32: n = NB_32;
      DLEN_64: n = NB_64;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  function automatic logic [4:0] map_off(input logic [3:0] sec, input logic [3:0] page,
                                         input logic [11:0] off);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < CFG_NUM; i++) begin
      if (sec == SEC_CFG && page == PAGE_CFG && off == CFG_OFFSET[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  assign cw_nxt   = {cw_r[15:0], rx_byte_i};
  assign cw_crc   = cw_r[CW_CRC];
  assign cw_read  = cw_r[CW_RW];
  assign nbyt     = dlen_bytes(cw_r[CW_DLEN_HI:CW_DLEN_LO]);
  assign wr_len   = 4'(HDR_BYTES + nbyt + {3'b000, cw_crc});
  assign data_pos = 4'(cnt_r - HDR_BYTES);
  assign map0     = map_off(cw_r[CW_SEC_HI:CW_SEC_LO], cw_r[CW_PAGE_HI:CW_PAGE_LO],
                            cw_r[CW_ADDR_HI:0]);
  assign map1     = map_off(cw_r[CW_SEC_HI:CW_SEC_LO], cw_r[CW_PAGE_HI:CW_PAGE_LO],
                            12'(cw_r[CW_ADDR_HI:0] + CFG_STRIDE));

  // ----------------------------------------------------------------
  // Byte events
  // ----------------------------------------------------------------
  // Address bytes win over a tx acknowledge in the same cycle
  assign open_st   = (st_r == ST_IDLE) || (st_r == ST_TX);
  assign new_pkt   = en_i && rx_valid_i && rx_addr_i && !rx_byte_i[0] && open_st;
  assign rd_addr   = en_i && rx_valid_i && rx_addr_i && rx_byte_i[0] && open_st && rd_armed_r;
  assign rx_data   = en_i && rx_valid_i && !rx_addr_i && (st_r == ST_IDLE) && (cnt_r != 4'h0);
  assign crc_pos   = rx_data && !cw_read && cw_crc && (cnt_r == 4'(HDR_BYTES + nbyt));
  assign stop_ev   = en_i && stop_i && (st_r == ST_IDLE) && (cnt_r != 4'h0) && !cw_read;
  assign len_ok    = (nbyt != 4'h0) && (cnt_r == wr_len);
  assign commit_go = stop_ev && len_ok && (!cw_crc || crc_ok_r) && map0[4];
  assign tx_step   = en_i && (st_r == ST_TX) && tx_ack_i && !rd_addr && !new_pkt;
  assign ptr_nxt   = 4'(ptr_r + 4'h1);
  assign tx_last   = (ptr_r == nbyt) || (!cw_crc && ptr_nxt == nbyt);

  // ----------------------------------------------------------------
  // Check byte accumulator
  // ----------------------------------------------------------------
  // A read resumes from the value held after the control word, so a retried
  // read address restarts the sum correctly without the control bytes again
  always_comb begin
    crc_src = crc_r;
    crc_dat = tx_byte_r;
    if (new_pkt) begin
      crc_src = CRC_INIT;
    end else if (rd_addr) begin
      crc_src = crc_cw_r;
    end
    if (new_pkt || rd_addr || rx_data) begin
      crc_dat = rx_byte_i;
    end
  end

  mcrb_crc8 u_crc (
    .crc_i  (crc_src),
    .data_i (crc_dat),
    .crc_o  (crc_out)
  );

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      crc_r    <= CRC_INIT;
      crc_cw_r <= CRC_INIT;
      crc_ok_r <= 1'b0;
    end else if (en_i) begin
      if (new_pkt || rd_addr || (rx_data && !crc_pos)) begin
        crc_r <= crc_out;
      end else if (tx_step && ptr_r < nbyt) begin
        crc_r <= crc_out;
      end
      if (rx_data && cnt_r == 4'(HDR_BYTES - 4'h1)) begin
        crc_cw_r <= crc_out;
      end
      if (new_pkt) begin
        crc_ok_r <= 1'b0;
      end else if (crc_pos) begin
        crc_ok_r <= (crc_r == rx_byte_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet reception
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r      <= 4'h0;
      cw_r       <= 24'h00_0000;
      wbuf_r     <= 64'h0000_0000_0000_0000;
      rd_armed_r <= 1'b0;
    end else if (en_i) begin
      if (new_pkt) begin
        cnt_r      <= 4'h1;
        rd_armed_r <= 1'b0;
      end else if (stop_i && st_r == ST_IDLE) begin
        cnt_r <= 4'h0;
      end else if (rx_data) begin
        if (cnt_r != CNT_MAX) begin
          cnt_r <= 4'(cnt_r + 4'h1);
        end
        if (cnt_r < HDR_BYTES) begin
          cw_r <= cw_nxt;
        end
        if (cnt_r == 4'(HDR_BYTES - 4'h1)) begin
          rd_armed_r <= cw_nxt[CW_RW];
        end else if (cnt_r >= HDR_BYTES && cw_read) begin
          rd_armed_r <= 1'b0;
        end
        if (cnt_r >= HDR_BYTES && data_pos < NB_64) begin
          wbuf_r[{data_pos[2:0], 3'b000} +: 8] <= rx_byte_i;
        end
      end else if (tx_step && tx_last) begin
        rd_armed_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= ST_IDLE;
    end else if (en_i) begin
      unique case (st_r)
        ST_IDLE: begin
          if (rd_addr) begin
            st_r <= ST_RD0;
          end else if (commit_go) begin
            st_r <= ST_WR0;
          end
        end
        ST_WR0: st_r <= (nbyt == NB_64 && map1[4]) ? ST_WR1 : ST_IDLE;
        ST_WR1: st_r <= ST_IDLE;
        ST_RD0: st_r <= ST_RD1;
        ST_RD1: st_r <= ST_RD2;
        ST_RD2: st_r <= ST_TX;
        ST_TX: begin
          if (rd_addr) begin
            st_r <= ST_RD0;
          end else if (new_pkt || stop_i || (tx_step && tx_last)) begin
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Storage port
  // ----------------------------------------------------------------
  // Only listed offsets are ever written; other locations stay untouched
  assign mem_we    = (st_r == ST_WR0 && map0[4]) || (st_r == ST_WR1 && map1[4]);
  assign mem_widx  = (st_r == ST_WR1) ? map1[3:0] : map0[3:0];
  assign mem_wmask = (nbyt == NB_16) ? 2'h1 : 2'h3;
  assign mem_wdata = (st_r == ST_WR1) ? wbuf_r[63:32] : wbuf_r[31:0];
  assign mem_ridx  = (st_r == ST_RD1) ? map1[3:0] : map0[3:0];

  mcrb_cfg_mem u_mem (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_r),
    .en_i    (en_i),
    .we_i    (mem_we),
    .widx_i  (mem_widx),
    .wmask_i (mem_wmask),
    .wdata_i (mem_wdata),
    .ridx_i  (mem_ridx),
    .rdata_o (mem_rdata),
    .word0_o (isd_w)
  );

  // ----------------------------------------------------------------
  // Read data and transmit
  // ----------------------------------------------------------------
  // Unlisted offsets read back as zero
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tbuf_r    <= 64'h0000_0000_0000_0000;
      ptr_r     <= 4'h0;
      tx_byte_r <= 8'h00;
    end else if (en_i) begin
      if (st_r == ST_RD1) begin
        tbuf_r[31:0] <= map0[4] ? mem_rdata : CFG_RESET;
        if (nbyt == NB_16) begin
          tbuf_r[31:HALF_W] <= 16'h0000;
        end
      end else if (st_r == ST_RD2) begin
        tbuf_r[63:32] <= map1[4] ? mem_rdata : CFG_RESET;
        tx_byte_r     <= tbuf_r[7:0];
        ptr_r         <= 4'h0;
      end else if (tx_step) begin
        ptr_r <= ptr_nxt;
        if (ptr_nxt < nbyt) begin
          tx_byte_r <= tbuf_r[{ptr_nxt[2:0], 3'b000} +: 8];
        end else if (cw_crc && ptr_nxt == nbyt) begin
          tx_byte_r <= crc_out;
        end
      end
    end
  end

  assign tx_valid_o = (st_r == ST_TX);
  assign tx_byte_o  = tx_byte_r;

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_done_o <= 1'b0;
      crc_err_o <= 1'b0;
    end else if (en_i) begin
      wr_done_o <= (st_r == ST_WR0 && !(nbyt == NB_64 && map1[4])) || (st_r == ST_WR1);
      crc_err_o <= stop_ev && len_ok && cw_crc && !crc_ok_r;
    end
  end

  // ----------------------------------------------------------------
  // Initial speed detect settings
  // ----------------------------------------------------------------
  assign parity_o                    = isd_w[ISD_PARITY];
  assign speed_detect_on_o           = isd_w[SPEED_DETECT_ON];
  assign braking_on_o                = isd_w[ISD_BRAKE];
  assign float_outputs_on_o          = isd_w[ISD_FLOAT];
  assign reverse_spin_on_o           = isd_w[ISD_REVERSE];
  assign resync_on_o                 = isd_w[ISD_RESYNC];
  assign forward_resync_threshold_o  = isd_w[ISD_THR_HI:ISD_THR_LO];
  assign braking_leg_select_o        = isd_w[ISD_LEG];
  assign braking_duration_o          = isd_w[ISD_BRK_HI:ISD_BRK_LO];
  assign float_duration_o            = isd_w[ISD_FLT_HI:ISD_FLT_LO];
  assign standstill_threshold_o      = isd_w[ISD_STL_HI:ISD_STL_LO];
  assign reverse_handoff_threshold_o = isd_w[ISD_HND_HI:ISD_HND_LO];
  assign reverse_open_loop_current_o = isd_w[ISD_OLC_HI:ISD_OLC_LO];

  // Table lookups lag the register by one cycle
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      braking_ms_o <= DUR_MS[0];
      float_ms_o   <= DUR_MS[0];
    end else if (en_i) begin
      braking_ms_o <= DUR_MS[isd_w[ISD_BRK_HI:ISD_BRK_LO]];
      float_ms_o   <= DUR_MS[isd_w[ISD_FLT_HI:ISD_FLT_LO]];
    end
  end

endmodule // mcrb_cfg_bank

//--- mcrb_cfg_bank_checker.sv
// Port checker for the configuration bank.
// Assumes bind into mcrb_cfg_bank by matching port names.
`timescale 1ns/1ps
module mcrb_cfg_bank_checker import mcrb_pkg::*; (
  input wire logic        mclk_i, nrst_i, rx_valid_i, rx_addr_i, stop_i, tx_ack_i,
  input wire logic        tx_valid_o, wr_done_o, crc_err_o, speed_detect_on_o,
  input wire logic        braking_on_o, braking_leg_select_o,
  input wire logic [7:0]  rx_byte_i, tx_byte_o,
  input wire logic [3:0]  braking_duration_o,
  input wire logic [13:0] braking_ms_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_err_after_stop: assert property (crc_err_o |-> $past(stop_i))
    else $error("crc_err not after stop");
  a_err_no_commit: assert property (crc_err_o |-> !wr_done_o [*3])
    else $error("bad write committed");
  a_done_after_stop: assert property (wr_done_o |-> $past(stop_i, 2) || $past(stop_i, 3))
    else $error("wr_done timing");
  a_done_one_pulse: assert property (wr_done_o |=> !wr_done_o)
    else $error("wr_done too long");
  a_cfg_on_commit: assert property ($changed({speed_detect_on_o, braking_on_o,
    braking_leg_select_o, braking_duration_o}) |-> $past(stop_i, 2)) else $error("cfg moved");
  a_brake_ms_map: assert property (braking_ms_o == DUR_MS[$past(braking_duration_o)])
    else $error("brake ms wrong");
  a_tx_byte_hold: assert property (tx_valid_o && !tx_ack_i && !rx_valid_i && !stop_i
    |=> tx_valid_o && $stable(tx_byte_o)) else $error("tx byte dropped");
  a_wr_ends_read: assert property (rx_valid_i && rx_addr_i && !rx_byte_i[0]
    |=> !tx_valid_o) else $error("read not abandoned");
  c_commit: cover property (wr_done_o);
  c_crc_drop: cover property (crc_err_o);
  c_tx_ack: cover property (tx_valid_o && tx_ack_i);
endmodule // mcrb_cfg_bank_checker
bind mcrb_cfg_bank mcrb_cfg_bank_checker u_chk (.*);

//--- mcrb_cfg_bank_tb.sv
// Bench for mcrb_cfg_bank; the controller model carries the packets.
// Assumes one model task at a time from the main sequence.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module mcrb_cfg_bank_tb;
  logic mclk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1, ok;
  logic rx_valid_i, rx_addr_i, stop_i, tx_ack_i, tx_valid_o, wr_done_o, crc_err_o;
  logic parity_o, speed_detect_on_o, braking_on_o, float_outputs_on_o, reverse_spin_on_o;
  logic resync_on_o, braking_leg_select_o;
  logic [7:0] rx_byte_i, tx_byte_o;
  logic [3:0] forward_resync_threshold_o, braking_duration_o, float_duration_o;
  logic [3:0] reverse_handoff_threshold_o;
  logic [13:0] braking_ms_o, float_ms_o;
  logic [2:0] standstill_threshold_o;
  logic [1:0] reverse_open_loop_current_o;
  logic [63:0] d;
  int fails = 0, checked = 0, cyc = 0, errs = 0, dones = 0;
  // Whole initial speed detect word as the outputs show it, reserved bits as zero
  wire [31:0] isd_seen = {parity_o, speed_detect_on_o, braking_on_o, float_outputs_on_o,
                          reverse_spin_on_o, resync_on_o, forward_resync_threshold_o,
                          braking_leg_select_o, 4'h0, braking_duration_o, float_duration_o,
                          standstill_threshold_o, reverse_handoff_threshold_o,
                          reverse_open_loop_current_o};
  always #25 mclk_i = ~mclk_i;
  mcrb_cfg_bank dut (.*);
  mcrb_ctrl_model u_ctrl (.*);
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the under 1500 cycles the tests need
  always @(posedge mclk_i) begin
    cyc++;
    if (crc_err_o === 1'b1) errs++;
    if (wr_done_o === 1'b1) dones++;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end
  function automatic logic [11:0] off(int i);
    return (i < 8) ? 12'h080 + 12'(2 * i) : 12'h094 + 12'(2 * (i - 8));
  endfunction
  task automatic t_reset();
    `CHK("brake_ms", 14'h000A, braking_ms_o)
    for (int i = 0; i < 7; i++) begin
      u_ctrl.rd(off(i), 2'h1, 1'b1, d, ok);
      `CHK("reset_val", 32'h0000_0000, d[31:0])
    end
    $display("t_reset done");
  endtask
  task automatic t_map();
    for (int i = 0; i < 14; i++) u_ctrl.wr(off(i), 2'h1, {40'h0, 8'(i), 4'h0, off(i)}, 1'b1, 1'b0);
    // Last two reads hit reserved offsets, never written
    for (int i = 0; i < 16; i++) begin
      u_ctrl.rd(i < 14 ? off(i) : 12'h090 + 12'(2 * (i - 14)), 2'h1, 1'b1, d, ok);
      `CHK("map", (i < 14 ? {40'h0, 8'(i), 4'h0, off(i)} : 64'h0), d)
      `CHK("rd_crc", 1'b1, ok)
    end
    $display("t_map done");
  endtask
  task automatic t_fields();
    logic [31:0] v [2] = '{32'hFC21_E1B7, 32'hA800_3E00};
    logic [27:0] ms [2] = '{{14'h3A98, 14'h000A}, {14'h0032, 14'h3A98}};
    for (int i = 0; i < 2; i++) begin
      u_ctrl.wr(12'h080, 2'h1, {32'h0, v[i]}, 1'b1, 1'b0);
      `CHK("en", v[i][30:28], {speed_detect_on_o, braking_on_o, float_outputs_on_o})
      `CHK("pr", {v[i][31], v[i][27:26]}, {parity_o, reverse_spin_on_o, resync_on_o})
      `CHK("leg", v[i][21], braking_leg_select_o)
      `CHK("brk", {v[i][16:13], ms[i]}, {braking_duration_o, braking_ms_o, float_ms_o})
      `CHK("word", {v[i][31:21], 4'h0, v[i][16:0]}, isd_seen)
    end
    $display("t_fields done");
  endtask
  task automatic t_crc();
    u_ctrl.wr(12'h082, 2'h1, 64'h0000_0000_1234_ABCD, 1'b1, 1'b0);
    u_ctrl.wr(12'h082, 2'h1, 64'h0000_0000_5555_AAAA, 1'b1, 1'b1);
    // Clock enable low: this whole write must be ignored
    en_i <= 1'b0;
    u_ctrl.wr(12'h082, 2'h1, 64'h0000_0000_FFFF_FFFF, 1'b1, 1'b0);
    en_i <= 1'b1;
    `CHK("crc_err", 1, errs)
    `CHK("wr_done", 17, dones)
    u_ctrl.wr(12'h082, 2'h0, 64'h0000_0000_0000_1357, 1'b0, 1'b0);
    u_ctrl.rd(12'h082, 2'h1, 1'b0, d, ok);
    `CHK("kept", 32'h1234_1357, d[31:0])
    u_ctrl.wr(12'h08C, 2'h2, 64'h89AB_CDEF_0123_4567, 1'b0, 1'b0);
    u_ctrl.rd(12'h08C, 2'h2, 1'b1, d, ok);
    `CHK("wide", 64'h89AB_CDEF_0123_4567, d)
    `CHK("wide_crc", 1'b1, ok)
    $display("t_crc done");
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_reset();
    t_map();
    t_fields();
    t_crc();
    complete_run();
  end
endmodule // mcrb_cfg_bank_tb

//--- mcrb_cfg_mem.sv
// Storage for the fourteen configuration words.
// Assumes a synchronised active-low reset and a clock enable from the bank.
`timescale 1ns/1ps
module mcrb_cfg_mem import mcrb_pkg::*; (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              en_i,
  // Write port, half-word lanes
  input  wire logic              we_i,
  input  wire logic [3:0]        widx_i,
  input  wire logic [1:0]        wmask_i,
  input  wire logic [WORD_W-1:0] wdata_i,
  // Registered read port
  input  wire logic [3:0]        ridx_i,
  output logic      [WORD_W-1:0] rdata_o,
  // Entry 0 always visible
  output logic      [WORD_W-1:0] word0_o
);

  logic [WORD_W-1:0] mem_r [CFG_NUM];

  // ----------------------------------------------------------------
  // Entries
  // ----------------------------------------------------------------
  // Entries without a defined reset still clear, so nothing starts unknown
  for (genvar g = 0; g < CFG_NUM; g++) begin : g_ent
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_r[g] <= CFG_RESET;
      end else if (en_i && we_i && widx_i == 4'(g)) begin
        if (wmask_i[0]) begin
          mem_r[g][HALF_W-1:0] <= wdata_i[HALF_W-1:0];
        end
        if (wmask_i[1]) begin
          mem_r[g][WORD_W-1:HALF_W] <= wdata_i[WORD_W-1:HALF_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= CFG_RESET;
    end else if (en_i) begin
      rdata_o <= (ridx_i < 4'(CFG_NUM)) ? mem_r[ridx_i] : CFG_RESET;
    end
  end

  assign word0_o = mem_r[0];

endmodule // mcrb_cfg_mem

//--- mcrb_crc8.sv
// One byte step of the packet check byte.
// Pure combinational; the caller holds the running value.
`timescale 1ns/1ps
module mcrb_crc8 import mcrb_pkg::*; (
  // Running value and byte
  input  wire logic [7:0] crc_i,
  input  wire logic [7:0] data_i,
  // Updated value
  output logic      [7:0] crc_o
);

  // ----------------------------------------------------------------
  // MSB first, no reflection, no final inversion
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ data_i;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_o = c;
  end

endmodule // mcrb_crc8

//--- mcrb_ctrl_model.sv
// Controller model: sends packets to the bank and reads data back.
// Assumes it is the only driver of the bank's byte and ack inputs.
`timescale 1ns/1ps
module mcrb_ctrl_model (
  input  wire logic       mclk_i,
  input  wire logic       tx_valid_o,
  input  wire logic [7:0] tx_byte_o,
  output logic            rx_valid_i, rx_addr_i, stop_i, tx_ack_i,
  output logic      [7:0] rx_byte_i
);
  logic [7:0] crc;
  initial {rx_valid_i, rx_addr_i, stop_i, tx_ack_i, rx_byte_i} = 12'h000;
  function automatic logic [7:0] step(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
    return c;
  endfunction
  // Idle line shows the inverse byte, never the stale one
  task automatic put(logic [7:0] b, logic a);
    @(posedge mclk_i);
    {rx_valid_i, rx_addr_i, rx_byte_i} <= {1'b1, a, b};
    crc = step(crc, b);
    @(posedge mclk_i);
    {rx_valid_i, rx_addr_i, rx_byte_i} <= {2'b00, ~b};
  endtask
  task automatic stop();
    @(posedge mclk_i);
    stop_i <= 1'b1;
    @(posedge mclk_i);
    stop_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic hdr(logic r, logic ce, logic [1:0] dl, logic [11:0] off);
    crc = 8'hFF;
    put(8'h02, 1'b1);
    put({r, ce, dl, 4'h0}, 1'b0);
    put({4'h0, off[11:8]}, 1'b0);
    put(off[7:0], 1'b0);
  endtask
  task automatic wr(logic [11:0] off, logic [1:0] dl, logic [63:0] d, logic ce, logic bad);
    hdr(1'b0, ce, dl, off);
    for (int i = 0; i < (2 << dl); i++) put(d[i*8 +: 8], 1'b0);
    if (ce) put(crc ^ {7'h00, bad}, 1'b0);
    stop();
  endtask
  task automatic rd(logic [11:0] off, logic [1:0] dl, logic ce, output logic [63:0] d,
                    output logic ok);
    int w;
    d = '0;
    ok = !ce;
    hdr(1'b1, ce, dl, off);
    put(8'h03, 1'b1);
    for (int i = 0; i < (2 << dl) + ce; i++) begin
      w = 0;
      @(posedge mclk_i);
      while (tx_valid_o !== 1'b1 && w < 40) begin
        @(posedge mclk_i);
        w++;
      end
      if (i < (2 << dl)) d[i*8 +: 8] = tx_byte_o;
      else ok = (tx_byte_o === crc);
      crc = step(crc, tx_byte_o);
      tx_ack_i <= 1'b1;
      @(posedge mclk_i);
      tx_ack_i <= 1'b0;
    end
    stop();
  endtask
endmodule // mcrb_ctrl_model

//--- mcrb_pkg.sv
// Package for the configuration register bank with packet check byte.
// Assumes an I2C target framing layer delivers bytes and start/stop events.
package mcrb_pkg;

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  localparam int          CFG_NUM    = 14;
  localparam int          WORD_W     = 32;
  localparam int          HALF_W     = 16;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [3:0]  SEC_CFG    = 4'h0;
  localparam logic [3:0]  PAGE_CFG   = 4'h0;
  localparam logic [11:0] CFG_STRIDE = 12'h002;
  // Entry 0 first: isd, reverse, spin-up a/b, loop a-d, speed curve a-f
  localparam logic [CFG_NUM-1:0][11:0] CFG_OFFSET = {
    12'h09E, 12'h09C, 12'h09A, 12'h098, 12'h096, 12'h094, 12'h08E,
    12'h08C, 12'h08A, 12'h088, 12'h086, 12'h084, 12'h082, 12'h080};

  // ----------------------------------------------------------------
  // Packet check byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // ----------------------------------------------------------------
  // Control word layout and packet lengths
  // ----------------------------------------------------------------
  localparam int         CW_RW      = 23;
  localparam int         CW_CRC     = 22;
  localparam int         CW_DLEN_HI = 21;
  localparam int         CW_DLEN_LO = 20;
  localparam int         CW_SEC_HI  = 19;
  localparam int         CW_SEC_LO  = 16;
  localparam int         CW_PAGE_HI = 15;
  localparam int         CW_PAGE_LO = 12;
  localparam int         CW_ADDR_HI = 11;
  localparam logic [1:0] DLEN_16    = 2'h0;
  localparam logic [1:0] DLEN_32    = 2'h1;
  localparam logic [1:0] DLEN_64    = 2'h2;
  localparam logic [3:0] NB_16      = 4'h2;
  localparam logic [3:0] NB_32      = 4'h4;
  localparam logic [3:0] NB_64      = 4'h8;
  localparam logic [3:0] HDR_BYTES  = 4'h4;
  localparam logic [3:0] CNT_MAX    = 4'hF;

  // ----------------------------------------------------------------
  // Initial speed detect fields
  // ----------------------------------------------------------------
  localparam int ISD_PARITY  = 31;
  localparam int SPEED_DETECT_ON      = 30;
  localparam int ISD_BRAKE   = 29;
  localparam int ISD_FLOAT   = 28;
  localparam int ISD_REVERSE = 27;
  localparam int ISD_RESYNC  = 26;
  localparam int ISD_THR_HI  = 25;
  localparam int ISD_THR_LO  = 22;
  localparam int ISD_LEG     = 21;
  localparam int ISD_BRK_HI  = 16;
  localparam int ISD_BRK_LO  = 13;
  localparam int ISD_FLT_HI  = 12;
  localparam int ISD_FLT_LO  = 9;
  localparam int ISD_STL_HI  = 8;
  localparam int ISD_STL_LO  = 6;
  localparam int ISD_HND_HI  = 5;
  localparam int ISD_HND_LO  = 2;
  localparam int ISD_OLC_HI  = 1;
  localparam int ISD_OLC_LO  = 0;

  // Durations in ms, code 0 last: 10 ms up to 15 s
  localparam logic [15:0][13:0] DUR_MS = {
    14'h3A98, 14'h2710, 14'h1D4C, 14'h1388, 14'h0FA0, 14'h0BB8, 14'h07D0, 14'h03E8,
    14'h02EE, 14'h01F4, 14'h0190, 14'h012C, 14'h00C8, 14'h0064, 14'h0032, 14'h000A};

  typedef enum logic [2:0] {
    ST_IDLE, ST_WR0, ST_WR1, ST_RD0, ST_RD1, ST_RD2, ST_TX
  } mcrb_state_t;

endpackage
